// file: hw/atcc_cfg.svh
// Summary of operation
// - complementary output of channel 0 active high when its polarity bit is 0
// - polarity bits ignore writes while protection level is 11 or 10
// - complementary enable bit turns the channel 0 complementary output on or off
// - main output of channel 0 active high when polarity is 0, low when 1
// - input edge: 00 rising, 01 falling, 11 both, 10 reserved (no edge)
// - counter reads current count; a software write replaces it at once
// - counter clock is the timer clock divided by divider value plus one
// - divider value reaches its working copy only at an update event
// - reload register is the counter's reload limit
// - 8-bit repeat counter counts down at each wrap; update event at a wrap that finds it at zero, then it reloads
// - enabled shadows refresh only at the reduced update rate
// - in input mode the value register holds last capture and is read-only
// - in output mode value register is compare; shadowed copy loads at update
// - counter, divider, reload, repeat, value registers take 16 and 32-bit access
// - channel 1 enable and polarity bits mirror channel 0 at bits 4 and 5
// - capture prescaler of a channel resets while its enable bit is clear
// - channel mode changes only while that channel's enable bit is clear
`ifndef ATCC_CFG_SVH
`define ATCC_CFG_SVH

// register offsets
`define ATCC_OFS_CHAN_CTL 8'h20
`define ATCC_OFS_COUNT 8'h24
`define ATCC_OFS_DIV 8'h28
`define ATCC_OFS_RELOAD 8'h2c
`define ATCC_OFS_REPEAT 8'h30
`define ATCC_OFS_CH0_VAL 8'h34
`define ATCC_OFS_CH1_VAL 8'h38

// channel control field positions
`define ATCC_BIT_CH0_EN 0
`define ATCC_BIT_CH0_P 1
`define ATCC_BIT_CH0_NEN 2
`define ATCC_BIT_CH0_NP 3
`define ATCC_BIT_CH1_EN 4
`define ATCC_BIT_CH1_P 5
`define ATCC_BIT_CH1_NEN 6
`define ATCC_BIT_CH1_NP 7
`define ATCC_CTL_POL_MASK 8'haa
`define ATCC_PROTECTION_LEVEL_LOCK_BIT 1

// access sizes and modes
`define ATCC_SIZE_HALF 2'h1
`define ATCC_SIZE_WORD 2'h2
`define ATCC_MODE_OUTPUT 2'h0

`endif

// file: hw/atcc_pkg.sv
`default_nettype none
package atcc_pkg;
  typedef logic [15:0] atcc_half_t;
  typedef logic [31:0] atcc_word_t;

  // prescaler state
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] shadow;
    logic tick;
  } atcc_psc_st_t;

  // channel state
  typedef struct packed {
    logic [1:0] mode;
    logic [15:0] value;
    logic [15:0] active;
    logic prev_in;
    logic [2:0] psc_cnt;
    logic out;
    logic out_n;
    logic cap_evt;
  } atcc_chan_st_t;

  // top state
  typedef struct packed {
    logic [7:0] ctl;
    logic [15:0] count;
    logic [15:0] div;
    logic [15:0] reload;
    logic [15:0] reload_act;
    logic [7:0] rep_val;
    logic [7:0] rep_cnt;
    logic update;
    logic [31:0] rdata;
    logic ack;
  } atcc_top_st_t;
endpackage : atcc_pkg
`default_nettype wire

// file: hw/atcc_prescale.sv
`default_nettype none
module atcc_prescale (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // control
  input wire logic i_run,
  input wire logic i_update,
  input wire atcc_pkg::atcc_half_t i_div_value,
  // counter clock enable
  output logic o_tick
);
  import atcc_pkg::*;

  atcc_psc_st_t st_reg;
  atcc_psc_st_t st_next;

  // divide by shadow plus one; a new divider waits for the update event
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (i_update) begin
      st_next.shadow = i_div_value;
    end
    if (i_run) begin
      if (st_reg.cnt >= st_reg.shadow) begin
        st_next.cnt = 16'h0000;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;

  // full period only while the shadow held; a lowered shadow cuts one period short
  div_period_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    st_reg.tick && $past(st_reg.shadow, 2) == $past(st_reg.shadow) |->
      st_reg.cnt == 16'h0000 && $past(st_reg.cnt) == $past(st_reg.shadow))
    else $error("prescaler tick at wrong count");

  shadow_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !i_update |=> $stable(st_reg.shadow))
    else $error("divider shadow changed without update");
endmodule // atcc_prescale
`default_nettype wire

// file: hw/atcc_channel.sv
`default_nettype none
`include "atcc_cfg.svh"
module atcc_channel (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // timebase
  input wire atcc_pkg::atcc_half_t i_count,
  input wire logic i_update,
  // control bits
  input wire logic i_enable,
  input wire logic i_polarity,
  input wire logic i_comp_enable,
  input wire logic i_comp_polarity,
  input wire logic [1:0] i_mode_req,
  input wire logic [1:0] i_cap_psc,
  input wire logic i_shadow_en,
  // software write of the value register
  input wire logic i_value_wr,
  input wire atcc_pkg::atcc_half_t i_wdata,
  // pin side
  input wire logic i_capture_input,
  output logic o_out,
  output logic o_out_n,
  // status
  output atcc_pkg::atcc_half_t o_value,
  output logic o_capture_event
);
  import atcc_pkg::*;

  atcc_chan_st_t st_reg;
  atcc_chan_st_t st_next;
  logic out_mode;
  logic edge_hit;
  logic cmp_ref;

  // edges needed before a capture, minus one
  function automatic logic [2:0] psc_limit(input logic [1:0] sel);
    case (sel)
      2'h0: psc_limit = 3'h0;
      2'h1: psc_limit = 3'h1;
      2'h2: psc_limit = 3'h3;
      default: psc_limit = 3'h7;
    endcase
  endfunction

  assign out_mode = (st_reg.mode == `ATCC_MODE_OUTPUT);
  assign cmp_ref = (i_count < st_reg.active);

  // active edge from the polarity pair; reserved code never captures
  always_comb begin
    case ({i_comp_polarity, i_polarity})
      2'b00: edge_hit = i_capture_input & ~st_reg.prev_in;
      2'b01: edge_hit = ~i_capture_input & st_reg.prev_in;
      2'b11: edge_hit = i_capture_input ^ st_reg.prev_in;
      default: edge_hit = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.cap_evt = 1'b0;
    st_next.prev_in = i_capture_input;
    // mode latched only while idle, so a live channel never flips role
    if (!i_enable) begin
      st_next.mode = i_mode_req;
      st_next.psc_cnt = 3'h0;
    end
    // capture path
    if (!out_mode && i_enable && edge_hit) begin
      if (st_reg.psc_cnt == psc_limit(i_cap_psc)) begin
        st_next.psc_cnt = 3'h0;
        st_next.value = i_count;
        st_next.cap_evt = 1'b1;
      end else begin
        st_next.psc_cnt = st_reg.psc_cnt + 3'h1;
      end
    end
    // software sees the value as read-only while capturing
    if (i_value_wr && out_mode) begin
      st_next.value = i_wdata;
    end
    // compare copy in use
    if (!i_shadow_en) begin
      st_next.active = st_next.value;
    end else if (i_update) begin
      st_next.active = st_reg.value;
    end
    // pins idle low outside output mode
    st_next.out = out_mode & i_enable & (cmp_ref ^ i_polarity);
    st_next.out_n = out_mode & i_comp_enable & (~cmp_ref ^ i_comp_polarity);
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_out = st_reg.out;
  assign o_out_n = st_reg.out_n;
  assign o_value = st_reg.value;
  assign o_capture_event = st_reg.cap_evt;

  capture_value_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    st_reg.cap_evt |-> st_reg.value == $past(i_count))
    else $error("captured value is not the count at the edge");

  psc_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !i_enable |=> st_reg.psc_cnt == 3'h0)
    else $error("capture prescaler not reset while disabled");

  mode_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_enable |=> $stable(st_reg.mode))
    else $error("mode changed while channel enabled");

  out_disable_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !i_enable |=> !st_reg.out)
    else $error("main output active while channel disabled");

  comp_level_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    out_mode && i_comp_enable && !cmp_ref |=> st_reg.out_n == !$past(i_comp_polarity))
    else $error("complementary output level wrong");
endmodule // atcc_channel
`default_nettype wire

// file: hw/atcc_top.sv
`default_nettype none
`include "atcc_cfg.svh"
module atcc_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // register port
  input wire logic i_bus_sel,
  input wire logic i_bus_write,
  input wire logic [7:0] i_bus_addr,
  input wire logic [1:0] i_bus_size,
  input wire atcc_pkg::atcc_word_t i_bus_wdata,
  output atcc_pkg::atcc_word_t o_bus_rdata,
  output logic o_bus_ack,
  // timer-level controls held outside this unit
  input wire logic i_count_enable,
  input wire logic [1:0] i_protection_level,
  input wire logic i_reload_shadow_en,
  // channel 0 configuration
  input wire logic [1:0] i_ch0_mode_req,
  input wire logic [1:0] i_ch0_cap_psc,
  input wire logic i_ch0_shadow_en,
  // channel 1 configuration
  input wire logic [1:0] i_ch1_mode_req,
  input wire logic [1:0] i_ch1_cap_psc,
  input wire logic i_ch1_shadow_en,
  // capture pins
  input wire logic i_ch0_capture_input,
  input wire logic i_ch1_capture_input,
  // compare pins
  output logic o_ch0_output_signal,
  output logic o_ch0_comp_output,
  output logic o_ch1_output_signal,
  output logic o_ch1_comp_output,
  // events
  output logic o_update_event,
  output logic o_ch0_capture_event,
  output logic o_ch1_capture_event
);
  import atcc_pkg::*;

  atcc_top_st_t st_reg;
  atcc_top_st_t st_next;
  logic bus_legal;
  logic bus_wr;
  logic bus_rd;
  logic wr_ctl;
  logic wr_count;
  logic wr_div;
  logic wr_reload;
  logic wr_rep;
  logic wr_ch0;
  logic wr_ch1;
  logic psc_tick;
  logic at_limit;
  logic protection_level_lock;
  logic [7:0] ctl_new;
  atcc_half_t rd_half;
  atcc_half_t ch0_value;
  atcc_half_t ch1_value;

  // write strobe for one offset
  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] ofs,
                                  input logic wr);
    wr_hit = wr && (addr == ofs);
  endfunction

  // only aligned half-word or word accesses move data; others are acked empty
  assign bus_legal = (i_bus_addr[1:0] == 2'h0) &&
                     ((i_bus_size == `ATCC_SIZE_HALF) || (i_bus_size == `ATCC_SIZE_WORD));
  assign bus_wr = i_bus_sel && i_bus_write && bus_legal;
  assign bus_rd = i_bus_sel && !i_bus_write && bus_legal;

  // write decode
  assign wr_ctl = wr_hit(i_bus_addr, `ATCC_OFS_CHAN_CTL, bus_wr);
  assign wr_count = wr_hit(i_bus_addr, `ATCC_OFS_COUNT, bus_wr);
  assign wr_div = wr_hit(i_bus_addr, `ATCC_OFS_DIV, bus_wr);
  assign wr_reload = wr_hit(i_bus_addr, `ATCC_OFS_RELOAD, bus_wr);
  assign wr_rep = wr_hit(i_bus_addr, `ATCC_OFS_REPEAT, bus_wr);
  assign wr_ch0 = wr_hit(i_bus_addr, `ATCC_OFS_CH0_VAL, bus_wr);
  assign wr_ch1 = wr_hit(i_bus_addr, `ATCC_OFS_CH1_VAL, bus_wr);

  // polarity lock from the protection level held outside
  assign protection_level_lock = i_protection_level[`ATCC_PROTECTION_LEVEL_LOCK_BIT];
  assign ctl_new = protection_level_lock ?
                   ((i_bus_wdata[7:0] & ~`ATCC_CTL_POL_MASK) |
                    (st_reg.ctl & `ATCC_CTL_POL_MASK)) :
                   i_bus_wdata[7:0];

  assign at_limit = (st_reg.count >= st_reg.reload_act);

  // read mux; unmapped offsets read zero
  always_comb begin
    case (i_bus_addr)
      `ATCC_OFS_CHAN_CTL: rd_half = {8'h00, st_reg.ctl};
      `ATCC_OFS_COUNT: rd_half = st_reg.count;
      `ATCC_OFS_DIV: rd_half = st_reg.div;
      `ATCC_OFS_RELOAD: rd_half = st_reg.reload;
      `ATCC_OFS_REPEAT: rd_half = {8'h00, st_reg.rep_val};
      `ATCC_OFS_CH0_VAL: rd_half = ch0_value;
      `ATCC_OFS_CH1_VAL: rd_half = ch1_value;
      default: rd_half = 16'h0000;
    endcase
  end

  // register file, counter and repetition logic
  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.update = 1'b0;
    st_next.rdata = 32'h0000_0000;
    // every selected access gets a one-cycle ack
    if (i_bus_sel) begin
      st_next.ack = 1'b1;
    end
    if (bus_rd) begin
      st_next.rdata = {16'h0000, rd_half};
    end
    if (wr_ctl) begin
      st_next.ctl = ctl_new;
    end
    if (wr_div) begin
      st_next.div = i_bus_wdata[15:0];
    end
    if (wr_reload) begin
      st_next.reload = i_bus_wdata[15:0];
    end
    // upper repeat bits are not stored, so they read back zero
    if (wr_rep) begin
      st_next.rep_val = i_bus_wdata[7:0];
    end
    // up-counting with wrap at the limit
    if (psc_tick) begin
      if (at_limit) begin
        st_next.count = 16'h0000;
        if (st_reg.rep_cnt == 8'h00) begin
          st_next.update = 1'b1;
          st_next.rep_cnt = st_reg.rep_val;
        end else begin
          st_next.rep_cnt = st_reg.rep_cnt - 8'h01;
        end
      end else begin
        st_next.count = st_reg.count + 16'h0001;
      end
    end
    // software write wins over the tick in the same cycle
    if (wr_count) begin
      st_next.count = i_bus_wdata[15:0];
    end
    // reload copy in use: direct, or only at the slowed update rate
    if (!i_reload_shadow_en) begin
      st_next.reload_act = st_next.reload;
    end else if (st_reg.update) begin
      st_next.reload_act = st_reg.reload;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // counter clock enable; divider change lands on the next update
  atcc_prescale u_prescale (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_run(i_count_enable),
    .i_update(st_reg.update),
    .i_div_value(st_reg.div),
    .o_tick(psc_tick)
  );

  // channel 0
  atcc_channel u_ch0 (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_count(st_reg.count),
    .i_update(st_reg.update),
    .i_enable(st_reg.ctl[`ATCC_BIT_CH0_EN]),
    .i_polarity(st_reg.ctl[`ATCC_BIT_CH0_P]),
    .i_comp_enable(st_reg.ctl[`ATCC_BIT_CH0_NEN]),
    .i_comp_polarity(st_reg.ctl[`ATCC_BIT_CH0_NP]),
    .i_mode_req(i_ch0_mode_req),
    .i_cap_psc(i_ch0_cap_psc),
    .i_shadow_en(i_ch0_shadow_en),
    .i_value_wr(wr_ch0),
    .i_wdata(i_bus_wdata[15:0]),
    .i_capture_input(i_ch0_capture_input),
    .o_out(o_ch0_output_signal),
    .o_out_n(o_ch0_comp_output),
    .o_value(ch0_value),
    .o_capture_event(o_ch0_capture_event)
  );

  // channel 1 uses the same logic on bits 4 to 7
  atcc_channel u_ch1 (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_count(st_reg.count),
    .i_update(st_reg.update),
    .i_enable(st_reg.ctl[`ATCC_BIT_CH1_EN]),
    .i_polarity(st_reg.ctl[`ATCC_BIT_CH1_P]),
    .i_comp_enable(st_reg.ctl[`ATCC_BIT_CH1_NEN]),
    .i_comp_polarity(st_reg.ctl[`ATCC_BIT_CH1_NP]),
    .i_mode_req(i_ch1_mode_req),
    .i_cap_psc(i_ch1_cap_psc),
    .i_shadow_en(i_ch1_shadow_en),
    .i_value_wr(wr_ch1),
    .i_wdata(i_bus_wdata[15:0]),
    .i_capture_input(i_ch1_capture_input),
    .o_out(o_ch1_output_signal),
    .o_out_n(o_ch1_comp_output),
    .o_value(ch1_value),
    .o_capture_event(o_ch1_capture_event)
  );

  // registered outputs
  assign o_bus_rdata = st_reg.rdata;
  assign o_bus_ack = st_reg.ack;
  assign o_update_event = st_reg.update;

  protection_level_lock_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    wr_ctl && protection_level_lock |=>
      (st_reg.ctl & `ATCC_CTL_POL_MASK) == ($past(st_reg.ctl) & `ATCC_CTL_POL_MASK))
    else $error("polarity bits changed while protected");

  count_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    wr_count |=> st_reg.count == $past(i_bus_wdata[15:0]))
    else $error("counter write not applied");

  count_wrap_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    psc_tick && at_limit && !wr_count |=> st_reg.count == 16'h0000)
    else $error("counter did not wrap at limit");

  count_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !psc_tick && !wr_count |=> $stable(st_reg.count))
    else $error("counter moved without a counter clock");

  repeat_update_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    psc_tick && at_limit && st_reg.rep_cnt == 8'h00 |=>
      st_reg.update && st_reg.rep_cnt == $past(st_reg.rep_val))
    else $error("update event missing at repeat zero");

  update_cause_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    st_reg.update |-> $past(st_reg.rep_cnt) == 8'h00 && $past(psc_tick))
    else $error("update event without repeat counter at zero");

  reload_shadow_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_reload_shadow_en && !st_reg.update |=> $stable(st_reg.reload_act))
    else $error("reload shadow refreshed between updates");

  read_ack_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    bus_rd && i_bus_addr == `ATCC_OFS_COUNT |=>
      o_bus_ack && o_bus_rdata == {16'h0000, $past(st_reg.count)})
    else $error("counter read returned wrong data");

  // every select is answered
  ack_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_bus_ack == $past(i_bus_sel))
    else $error("ack not one cycle after select");

  // data only after a legal read
  rdata_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !bus_rd |=> o_bus_rdata == 32'h0000_0000)
    else $error("read data not zero");

  // 16-bit registers, upper half zero
  rdata_upper_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_bus_rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

  // unlocked control write lands whole
  ctl_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    wr_ctl && !protection_level_lock |=> st_reg.ctl == $past(i_bus_wdata[7:0]))
    else $error("control write lost");

  // one step per counter clock
  count_step_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    psc_tick && !at_limit && !wr_count |=> st_reg.count == $past(st_reg.count) + 16'h0001)
    else $error("counter did not step");

  // wrap short of zero steps repeat down
  repeat_step_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    psc_tick && at_limit && st_reg.rep_cnt != 8'h00 |=>
      !st_reg.update && st_reg.rep_cnt == $past(st_reg.rep_cnt) - 8'h01)
    else $error("repeat counter did not step");

  // low 8 repeat bits kept
  rep_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    wr_rep |=> st_reg.rep_val == $past(i_bus_wdata[7:0]))
    else $error("repeat write lost");

  // unshadowed limit follows register
  reload_direct_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !i_reload_shadow_en |=> st_reg.reload_act == st_reg.reload)
    else $error("limit in use differs");

  // shadowed limit loads at update
  reload_load_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_reload_shadow_en && st_reg.update |=> st_reg.reload_act == $past(st_reg.reload))
    else $error("limit shadow not loaded");
endmodule // atcc_top
`default_nettype wire

// file: tb/atcc_pin_model.sv
`default_nettype none
module atcc_pin_model (
  // clock
  input wire logic i_core_clk,
  // compare pins seen
  input wire logic i_ch0_out,
  input wire logic i_ch0_comp,
  input wire logic i_ch1_out,
  input wire logic i_ch1_comp,
  // capture pins driven
  output logic o_ch0_pin,
  output logic o_ch1_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins idle low, so the first toggle is a rising edge
  initial begin
    o_ch0_pin = 1'b0;
    o_ch1_pin = 1'b0;
  end

  // edges spaced apart so each is seen on its own
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (3) @(negedge i_core_clk);
      o_ch0_pin = ~o_ch0_pin;
      o_ch1_pin = ~o_ch1_pin;
    end
    repeat (3) @(negedge i_core_clk);
  endtask

  // high cycles of each compare pin; two cycles skipped for the output register
  task automatic watch(input int cyc, output int h0, output int n0, output int h1,
                       output int n1);
    h0 = 0;
    n0 = 0;
    h1 = 0;
    n1 = 0;
    repeat (2) @(negedge i_core_clk);
    repeat (cyc) begin
      @(negedge i_core_clk);
      h0 += (i_ch0_out === 1'b1);
      n0 += (i_ch0_comp === 1'b1);
      h1 += (i_ch1_out === 1'b1);
      n1 += (i_ch1_comp === 1'b1);
    end
  endtask
endmodule // atcc_pin_model
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
`include "atcc_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import atcc_pkg::*;
  logic i_core_clk = 1'b0, i_rstn = 1'b0, i_bus_sel = 1'b0, i_bus_write = 1'b0;
  logic [7:0] i_bus_addr = 8'h00;
  logic [1:0] i_bus_size = 2'h0, i_protection_level = 2'h0;
  logic [1:0] i_ch0_mode_req = 2'h0, i_ch0_cap_psc = 2'h0;
  logic [1:0] i_ch1_mode_req = 2'h0, i_ch1_cap_psc = 2'h0;
  logic i_count_enable = 1'b0, i_reload_shadow_en = 1'b0;
  logic i_ch0_shadow_en = 1'b0, i_ch1_shadow_en = 1'b0;
  atcc_word_t i_bus_wdata = 32'h0, o_bus_rdata;
  logic o_bus_ack, o_ch0_output_signal, o_ch0_comp_output, o_ch1_output_signal;
  logic o_ch1_comp_output, o_update_event, o_ch0_capture_event, o_ch1_capture_event;
  wire i_ch0_capture_input, i_ch1_capture_input;
  logic [63:0] notes [$];
  int mismatches = 0, n_tests = 0, seed = 19114, cap0 = 0, cap1 = 0;

  always #4 i_core_clk = ~i_core_clk;

  atcc_top u_dut (
    .i_core_clk, .i_rstn, .i_bus_sel, .i_bus_write, .i_bus_addr, .i_bus_size,
    .i_bus_wdata, .o_bus_rdata, .o_bus_ack, .i_count_enable, .i_protection_level,
    .i_reload_shadow_en, .i_ch0_mode_req, .i_ch0_cap_psc, .i_ch0_shadow_en,
    .i_ch1_mode_req, .i_ch1_cap_psc, .i_ch1_shadow_en, .i_ch0_capture_input,
    .i_ch1_capture_input, .o_ch0_output_signal, .o_ch0_comp_output,
    .o_ch1_output_signal, .o_ch1_comp_output, .o_update_event, .o_ch0_capture_event,
    .o_ch1_capture_event
  );

  atcc_pin_model u_pins (
    .i_core_clk, .i_ch0_out(o_ch0_output_signal), .i_ch0_comp(o_ch0_comp_output),
    .i_ch1_out(o_ch1_output_signal), .i_ch1_comp(o_ch1_comp_output),
    .o_ch0_pin(i_ch0_capture_input), .o_ch1_pin(i_ch1_capture_input)
  );

  task automatic summarize();
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one selected edge per access; the note carries compare mask and expected data
  task automatic bus(input logic wr, input logic [7:0] a, input logic [1:0] sz,
                     input atcc_word_t d, input atcc_word_t m, input atcc_word_t e,
                     output atcc_word_t r);
    @(negedge i_core_clk);
    {i_bus_sel, i_bus_write, i_bus_addr, i_bus_size, i_bus_wdata} = {1'b1, wr, a, sz, d};
    notes.push_back({m, e});
    @(negedge i_core_clk);
    r = o_bus_rdata;
    i_bus_sel = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input atcc_word_t d);
    atcc_word_t r;
    bus(1'b1, a, `ATCC_SIZE_WORD, d, '1, 32'h0, r);
  endtask

  task automatic rd(input logic [7:0] a, input atcc_word_t e);
    atcc_word_t r;
    bus(1'b0, a, `ATCC_SIZE_HALF, 32'h0, '1, e, r);
  endtask

  // cycles between two update pulses, bounded so a dead counter cannot hang
  task automatic gap(output int g);
    int k;
    k = 0;
    while (o_update_event !== 1'b1 && k < 3000) begin
      @(negedge i_core_clk);
      k++;
    end
    g = 0;
    do begin
      @(negedge i_core_clk);
      g++;
    end while (o_update_event !== 1'b1 && g < 3000);
  endtask

  // ack stands one cycle, so mid-cycle sampling sees it settled
  always @(negedge i_core_clk) begin : mon
    logic [63:0] nt;
    if (o_bus_ack === 1'b1) begin
      nt = notes.pop_front();
      if (nt[63:32] != 32'h0) check(o_bus_rdata & nt[63:32], nt[31:0]);
    end
    if (o_ch0_capture_event === 1'b1) cap0++;
    if (o_ch1_capture_event === 1'b1) cap1++;
  end

  // watchdog well past the expected run length
  initial begin
    #(100000 * 8);
    mismatches++;
    summarize();
  end

  initial begin
    atcc_word_t r, v;
    logic [7:0] a;
    int g, h0, n0, h1, n1, eo, en;
    logic [1:0] pl [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    logic [7:0] pw [4] = '{8'hff, 8'h00, 8'h55, 8'h00};
    logic [7:0] pe [4] = '{8'hff, 8'haa, 8'hff, 8'h00};
    int td [3] = '{2, 1, 0};
    int tr [3] = '{2, 4, 2};
    int tp [3] = '{1, 0, 1};
    logic [3:0] ce [4] = '{4'h1, 4'h3, 4'hb, 4'h9};
    int cx [4] = '{1, 1, 2, 0};
    repeat (16) @(negedge i_core_clk);
    i_rstn = 1'b1;
    // reset values, then one unmapped offset
    for (int i = 32'h20; i <= 32'h3c; i += 4) rd(8'(i), 32'h0);
    // random data, half and word writes alternating
    for (int i = 0; i < 5; i++) begin
      v = $random(seed);
      a = 8'h24 + 8'(4 * i);
      bus(1'b1, a, i[0] ? `ATCC_SIZE_HALF : `ATCC_SIZE_WORD, v, '1, 32'h0, r);
      rd(a, a == `ATCC_OFS_REPEAT ? {24'h0, v[7:0]} : {16'h0, v[15:0]});
    end
    // byte write dropped, misaligned read gives zero
    wr(`ATCC_OFS_DIV, 32'h0abc);
    bus(1'b1, `ATCC_OFS_DIV, 2'h0, 32'h1111, '1, 32'h0, r);
    bus(1'b0, 8'h2a, `ATCC_SIZE_HALF, 32'h0, '1, 32'h0, r);
    rd(`ATCC_OFS_DIV, 32'h0abc);
    // polarity bits frozen while protection bit 1 is set
    for (int i = 0; i < 4; i++) begin
      i_protection_level = pl[i];
      wr(`ATCC_OFS_CHAN_CTL, {24'h0, pw[i]});
      rd(`ATCC_OFS_CHAN_CTL, {24'h0, pe[i]});
    end
    // new divider must wait for an update; no update happens with a huge limit
    wr(`ATCC_OFS_RELOAD, 32'hffff);
    wr(`ATCC_OFS_DIV, 32'h7);
    wr(`ATCC_OFS_COUNT, 32'h0);
    i_count_enable = 1'b1;
    repeat (20) @(negedge i_core_clk);
    i_count_enable = 1'b0;
    bus(1'b0, `ATCC_OFS_COUNT, `ATCC_SIZE_HALF, 32'h0, 32'h0, 32'h0, r);
    check(r >= 16 && r <= 24, 1'b1);
    // update spacing is (div+1)*(limit+1)*(repeat+1); early gaps settle shadows
    i_count_enable = 1'b1;
    for (int i = 0; i < 3; i++) begin
      i_reload_shadow_en = (i != 0);
      wr(`ATCC_OFS_DIV, td[i]);
      wr(`ATCC_OFS_RELOAD, tr[i]);
      wr(`ATCC_OFS_REPEAT, tp[i]);
      repeat (3) gap(g);
      check(g, (td[i] + 1) * (tr[i] + 1) * (tp[i] + 1));
    end
    // compare at 1 of a 4-count period: ref high one cycle in four
    wr(`ATCC_OFS_RELOAD, 32'h3);
    wr(`ATCC_OFS_REPEAT, 32'h0);
    wr(`ATCC_OFS_CH0_VAL, 32'h1);
    wr(`ATCC_OFS_CH1_VAL, 32'h1);
    repeat (2) gap(g);
    for (int c = 0; c < 16; c++) begin
      wr(`ATCC_OFS_CHAN_CTL, {24'h0, 4'(c), 4'(c)});
      u_pins.watch(40, h0, n0, h1, n1);
      eo = c[0] ? (c[1] ? 30 : 10) : 0;
      en = c[2] ? (c[3] ? 10 : 30) : 0;
      check(h0, eo);
      check(n0, en);
      check(h1, eo);
      check(n1, en);
    end
    // shadowed compare keeps the old value until an update
    i_count_enable = 1'b0;
    wr(`ATCC_OFS_COUNT, 32'h0);
    wr(`ATCC_OFS_CHAN_CTL, 32'h1);
    i_ch0_shadow_en = 1'b1;
    wr(`ATCC_OFS_CH0_VAL, 32'h0);
    repeat (3) @(negedge i_core_clk);
    check(o_ch0_output_signal, 1'b1);
    i_ch0_shadow_en = 1'b0;
    wr(`ATCC_OFS_CH0_VAL, 32'h0);
    repeat (3) @(negedge i_core_clk);
    check(o_ch0_output_signal, 1'b0);
    // input mode chosen while disabled; each edge code over one rise and one fall
    wr(`ATCC_OFS_CHAN_CTL, 32'h0);
    i_ch0_mode_req = 2'h1;
    i_ch1_mode_req = 2'h1;
    wr(`ATCC_OFS_COUNT, 32'h1234);
    for (int k = 0; k < 4; k++) begin
      wr(`ATCC_OFS_CHAN_CTL, {24'h0, ce[k], ce[k]});
      cap0 = 0;
      cap1 = 0;
      u_pins.toggle(2);
      check(cap0, cx[k]);
      check(cap1, cx[k]);
    end
    rd(`ATCC_OFS_CH0_VAL, 32'h1234);
    wr(`ATCC_OFS_CH0_VAL, 32'h5555);
    rd(`ATCC_OFS_CH0_VAL, 32'h1234);
    // every second rise captures; disabling clears the half-done count
    wr(`ATCC_OFS_CHAN_CTL, 32'h1);
    i_ch0_cap_psc = 2'h1;
    cap0 = 0;
    u_pins.toggle(8);
    u_pins.toggle(2);
    wr(`ATCC_OFS_CHAN_CTL, 32'h0);
    u_pins.toggle(2);
    wr(`ATCC_OFS_CHAN_CTL, 32'h1);
    u_pins.toggle(2);
    check(cap0, 2);
    // mode request ignored while enabled: still input, value stays read-only
    i_ch0_mode_req = 2'h0;
    wr(`ATCC_OFS_CH0_VAL, 32'h7777);
    rd(`ATCC_OFS_CH0_VAL, 32'h1234);
    check(o_ch0_output_signal, 1'b0);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
